// File: fesc_ctrl.sv
/*
 * Flash erase-suspend controller with programmer access gating.
 * Assumes all inputs are synchronous to ref_clk; the flash array, the
 * serial programmer protocol and the command decoder live outside.
 */
// Overview of operation
// - Compare received programmer ID codes with stored codes, report match.
// - Single-wire serial mode uses the mode pin as bidirectional data.
// - Parallel mode takes command, address, data and returns read data.
// - Code protection refuses parallel read and rewrite requests.
// - Interrupt ack during suspendable erase sets suspend request if enabled.
// - Erase halts only after the fixed suspend latency elapses.
// - While suspended, every block except the interrupted one is usable.
// - Writing 0 to the suspend request resumes the interrupted erase.
// - Without suspend, interrupts are serviced while erase keeps running.
// - Suspension begins only if erase suspend enable is 1 as the latency wait starts.
// - Suspended status flag reads 1 while erase is suspended.
`timescale 1ns/1ps
module fesc_ctrl (
    input  wire logic                          ref_clk,
    input  wire logic                          resetn,
    input  wire logic                          erase_start,
    input  wire logic [fesc_pkg::BLK_W-1:0]    erase_block,
    input  wire logic                          erase_suspend_enable,
    input  wire logic                          irq_auto_suspend_enable,
    input  wire logic                          req_write,
    input  wire logic                          req_value,
    input  wire logic                          irq_ack,
    input  wire logic                          acc_req,
    input  wire logic [fesc_pkg::BLK_W-1:0]    acc_block,
    output logic                               acc_grant_ff,
    output logic                               erase_busy_ff,
    output logic                               erase_done_ff,
    output logic                               erase_suspend_request_ff,
    output logic                               suspended_status_flag_ff,
    input  wire logic                          id_valid,
    input  wire logic [fesc_pkg::ID_W-1:0]     id_rx,
    input  wire logic [fesc_pkg::ID_W-1:0]     id_stored,
    output logic                               id_match_ff,
    output logic                               id_checked_ff,
    input  wire logic                          mode_pin_in,
    output logic                               mode_pin_out_ff,
    output logic                               mode_pin_oe_n_ff,
    input  wire logic                          sio_tx_en,
    input  wire logic                          sio_tx_bit,
    output logic                               sio_rx_bit_ff,
    output logic                               serial_2wire_ff,
    input  wire logic                          par_mode,
    input  wire logic                          code_protect,
    input  wire logic                          par_rd,
    input  wire logic                          par_wr,
    input  wire logic [fesc_pkg::PADDR_W-1:0]  par_addr,
    input  wire logic [fesc_pkg::PDATA_W-1:0]  par_wdata,
    input  wire logic [fesc_pkg::PDATA_W-1:0]  flash_rdata,
    output logic [fesc_pkg::PDATA_W-1:0]       par_rdata_ff,
    output logic                               flash_rd_ff,
    output logic                               flash_wr_ff,
    output logic [fesc_pkg::PADDR_W-1:0]       flash_addr_ff,
    output logic [fesc_pkg::PDATA_W-1:0]       flash_wdata_ff,
    output logic                               par_refused_ff
);
    import fesc_pkg::*;

    fesc_state_t            state_ff;
    fesc_state_t            nxt_state;
    logic [CNT_W-1:0]       lat_cnt_ff;
    logic [CNT_W-1:0]       erase_cnt_ff;
    logic [BLK_W-1:0]       blk_ff;
    logic                   strap_done_ff;

    // Erase is in a state where a suspend may still be pending or taken
    function automatic logic erasing(input fesc_state_t s);
        return (s == FESC_ERASE) || (s == FESC_PENDING);
    endfunction

    // ****************************************************************
    // Suspend request bit
    // ****************************************************************
    // Auto set on interrupt ack beats a software clear in the same cycle,
    // so an interrupt arriving during the clear is never lost.
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            erase_suspend_request_ff <= RST_REQ;
        end else if (irq_ack && irq_auto_suspend_enable
                     && erase_suspend_enable && erasing(state_ff)) begin
            erase_suspend_request_ff <= 1'b1;
        end else if (req_write) begin
            erase_suspend_request_ff <= req_value;
        end
    end

    // ****************************************************************
    // Erase sequencer
    // ****************************************************************
    // Next state; without enable a request never starts the latency wait, so
    // interrupts simply run beside the ongoing erase.
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            FESC_IDLE: begin
                if (erase_start) begin
                    nxt_state = FESC_ERASE;
                end
            end
            FESC_ERASE: begin
                if (erase_cnt_ff == CNT_W'(ERASE_TIME_CYC - 1)) begin
                    nxt_state = FESC_IDLE;
                end else if (erase_suspend_request_ff
                             && erase_suspend_enable) begin
                    nxt_state = FESC_PENDING;
                end
            end
            FESC_PENDING: begin
                if (!erase_suspend_request_ff) begin
                    nxt_state = FESC_ERASE;
                end else if (lat_cnt_ff ==
                             CNT_W'(SUSPEND_LATENCY_CYC - 1)) begin
                    nxt_state = FESC_SUSP;
                end
            end
            FESC_SUSP: begin
                if (!erase_suspend_request_ff) begin
                    nxt_state = FESC_ERASE;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            state_ff <= FESC_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Erase keeps progressing during the latency window; only the
    // suspended state freezes the counter, so resume picks up in place.
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            erase_cnt_ff <= '0;
            lat_cnt_ff   <= '0;
            blk_ff       <= '0;
        end else begin
            if (state_ff == FESC_IDLE && erase_start) begin
                erase_cnt_ff <= '0;
                blk_ff       <= erase_block;
            end else if (erasing(state_ff)) begin
                erase_cnt_ff <= erase_cnt_ff + CNT_W'(1);
            end
            if (state_ff == FESC_PENDING) begin
                lat_cnt_ff <= lat_cnt_ff + CNT_W'(1);
            end else begin
                lat_cnt_ff <= '0;
            end
        end
    end

    // Busy, done and suspended flag are registered from nxt_state and so match the state; grant follows one cycle later
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            erase_busy_ff            <= 1'b0;
            erase_done_ff            <= 1'b0;
            suspended_status_flag_ff <= 1'b0;
            acc_grant_ff             <= 1'b0;
        end else begin
            erase_busy_ff            <= (nxt_state != FESC_IDLE);
            erase_done_ff            <= (state_ff == FESC_ERASE)
                                        && (nxt_state == FESC_IDLE);
            suspended_status_flag_ff <= (nxt_state == FESC_SUSP);
            // The interrupted block stays locked out while suspended
            acc_grant_ff <= acc_req && (state_ff == FESC_SUSP)
                            && (acc_block != blk_ff);
        end
    end

    // ****************************************************************
    // Programmer access
    // ****************************************************************
    // ID comparison registered once per presented code set
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            id_match_ff   <= 1'b0;
            id_checked_ff <= 1'b0;
        end else begin
            id_checked_ff <= id_valid;
            if (id_valid) begin
                id_match_ff <= (id_rx == id_stored);
            end
        end
    end

    // Mode strap caught on the first clock after reset release
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            strap_done_ff   <= 1'b0;
            serial_2wire_ff <= 1'b0;
        end else if (!strap_done_ff) begin
            strap_done_ff   <= 1'b1;
            serial_2wire_ff <= !mode_pin_in;
        end
    end

    // Mode pin as shared serial data; enable low while driving
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            mode_pin_out_ff  <= 1'b1;
            mode_pin_oe_n_ff <= 1'b1;
            sio_rx_bit_ff    <= 1'b1;
        end else begin
            mode_pin_out_ff  <= sio_tx_bit;
            mode_pin_oe_n_ff <= !(sio_tx_en && strap_done_ff
                                  && !serial_2wire_ff);
            sio_rx_bit_ff    <= mode_pin_in;
        end
    end

    // Parallel port: protection blocks both reads and rewrites
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            flash_rd_ff    <= 1'b0;
            flash_wr_ff    <= 1'b0;
            flash_addr_ff  <= '0;
            flash_wdata_ff <= '0;
            par_rdata_ff   <= '0;
            par_refused_ff <= 1'b0;
        end else begin
            flash_rd_ff    <= par_mode && par_rd && !code_protect;
            flash_wr_ff    <= par_mode && par_wr && !code_protect;
            par_refused_ff <= par_mode && (par_rd || par_wr)
                              && code_protect;
            flash_addr_ff  <= par_addr;
            flash_wdata_ff <= par_wdata;
            par_rdata_ff   <= code_protect ? '0 : flash_rdata;
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    a_auto_req_set: assert property (@(posedge ref_clk) disable iff (!resetn)
        irq_ack && irq_auto_suspend_enable && erase_suspend_enable
        && erasing(state_ff) |=> erase_suspend_request_ff)
        else $error("auto suspend request not set");
    a_latency_wait: assert property (@(posedge ref_clk) disable iff (!resetn)
        state_ff == FESC_ERASE && nxt_state == FESC_PENDING
        |=> !suspended_status_flag_ff [*2])
        else $error("suspend taken before latency");
    a_no_susp_off: assert property (@(posedge ref_clk) disable iff (!resetn)
        state_ff == FESC_ERASE && !erase_suspend_enable
        |=> state_ff != FESC_PENDING)
        else $error("suspend without enable");
    a_flag_state: assert property (@(posedge ref_clk) disable iff (!resetn)
        suspended_status_flag_ff == (state_ff == FESC_SUSP))
        else $error("suspend flag mismatch");
    a_resume_clear: assert property (@(posedge ref_clk) disable iff (!resetn)
        state_ff == FESC_SUSP && !erase_suspend_request_ff
        |=> !suspended_status_flag_ff && state_ff == FESC_ERASE)
        else $error("resume failed");
    a_resume_block: assert property (@(posedge ref_clk) disable iff (!resetn)
        state_ff == FESC_SUSP |=> $stable(blk_ff)
        && $stable(erase_cnt_ff))
        else $error("erase progress lost in suspend");
    a_block_locked: assert property (@(posedge ref_clk) disable iff (!resetn)
        acc_req && acc_block == blk_ff |=> !acc_grant_ff)
        else $error("interrupted block accessed");
    a_protect_rd: assert property (@(posedge ref_clk) disable iff (!resetn)
        code_protect |=> !flash_rd_ff && !flash_wr_ff)
        else $error("protected flash accessed");
    a_id_match: assert property (@(posedge ref_clk) disable iff (!resetn)
        id_valid |=> id_checked_ff && id_match_ff
        == ($past(id_rx) == $past(id_stored)))
        else $error("id compare wrong");
    a_par_access: assert property (@(posedge ref_clk) disable iff (!resetn)
        par_mode && par_wr && !code_protect |=> flash_wr_ff)
        else $error("parallel write dropped");
endmodule

// File: fesc_pkg.sv
/*
 * Package for the flash erase-suspend controller: states, widths and
 * timing counts.
 * Assumes a single 20 MHz clock shared with the rest of the MCU.
 */
package fesc_pkg;
    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int unsigned CLK_PERIOD_NS       = 50;
    localparam int unsigned SUSPEND_LATENCY_NS  = 20000;
    localparam int unsigned SUSPEND_LATENCY_CYC =
        (SUSPEND_LATENCY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned ERASE_TIME_CYC      = 2000;
    localparam int unsigned CNT_W               = 12;

    // ****************************************************************
    // Widths and reset values
    // ****************************************************************
    localparam int unsigned ID_W      = 56;
    localparam int unsigned BLK_W     = 3;
    localparam int unsigned PADDR_W   = 16;
    localparam int unsigned PDATA_W   = 8;
    localparam logic        RST_REQ   = 1'b0;

    // ****************************************************************
    // Erase sequencer states
    // ****************************************************************
    typedef enum logic [3:0] {
        FESC_IDLE    = 4'b0001,
        FESC_ERASE   = 4'b0010,
        FESC_PENDING = 4'b0100,
        FESC_SUSP    = 4'b1000
    } fesc_state_t;
endpackage

// File: fesc_prog_model.sv
/*
 * Behavioural model of the external serial programmer on the mode pin.
 * Assumes the device drives the pin when its enable is low; the board
 * has a pull-up, so a released pin reads high.
 */
`timescale 1ns/1ps
module fesc_prog_model (
    input  wire logic strap_low,
    input  wire logic prog_en,
    input  wire logic prog_bit,
    input  wire logic dev_out,
    input  wire logic dev_oe_n,
    output logic      pin
);
    // ****************************************************************
    // Pin resolution
    // ****************************************************************
    // Device first, then programmer data, then strap, else pull-up
    always_comb begin
        if (!dev_oe_n) begin
            pin = dev_out;
        end else if (prog_en) begin
            pin = prog_bit;
        end else begin
            pin = !strap_low;
        end
    end
endmodule

// File: tb_top.sv
/*
 * Self-checking bench for the erase-suspend controller.
 * Assumes inputs change at the falling edge and that the programmer
 * model resolves the shared mode pin.
 */
`timescale 1ns/1ps
module tb_top;
    import fesc_pkg::*;
    logic ref_clk = 0, resetn = 0, erase_start = 0, req_write = 0;
    logic erase_suspend_enable = 1, irq_auto_suspend_enable = 1;
    logic req_value = 0, irq_ack = 0, acc_req = 0, id_valid = 0;
    logic sio_tx_en = 0, sio_tx_bit = 1, par_mode = 1, code_protect = 0;
    logic par_rd = 0, par_wr = 0, strap_low = 0, prog_en = 0, prog_bit = 1;
    logic [BLK_W-1:0] erase_block = 0, acc_block = 0;
    logic [ID_W-1:0] id_stored = 56'h0123456789abcd, id_rx = 0;
    logic [PADDR_W-1:0] par_addr = 0, flash_addr_ff;
    logic [PDATA_W-1:0] par_wdata = 0, flash_rdata = 8'h5a;
    logic [PDATA_W-1:0] par_rdata_ff, flash_wdata_ff;
    logic acc_grant_ff, erase_busy_ff, erase_done_ff, id_match_ff;
    logic erase_suspend_request_ff, suspended_status_flag_ff;
    logic id_checked_ff, mode_pin_out_ff, mode_pin_oe_n_ff, sio_rx_bit_ff;
    logic serial_2wire_ff, flash_rd_ff, flash_wr_ff, par_refused_ff;
    logic mode_pin_in;
    logic [6:0] rows [4];
    int errors = 0, num_checks = 0, n;

    fesc_ctrl dut (.ref_clk(ref_clk), .resetn(resetn),
        .erase_start(erase_start), .erase_block(erase_block),
        .erase_suspend_enable(erase_suspend_enable),
        .irq_auto_suspend_enable(irq_auto_suspend_enable),
        .req_write(req_write), .req_value(req_value),
        .irq_ack(irq_ack), .acc_req(acc_req), .acc_block(acc_block),
        .acc_grant_ff(acc_grant_ff), .erase_busy_ff(erase_busy_ff),
        .erase_done_ff(erase_done_ff),
        .erase_suspend_request_ff(erase_suspend_request_ff),
        .suspended_status_flag_ff(suspended_status_flag_ff),
        .id_valid(id_valid), .id_rx(id_rx), .id_stored(id_stored),
        .id_match_ff(id_match_ff), .id_checked_ff(id_checked_ff),
        .mode_pin_in(mode_pin_in), .mode_pin_out_ff(mode_pin_out_ff),
        .mode_pin_oe_n_ff(mode_pin_oe_n_ff), .sio_tx_en(sio_tx_en),
        .sio_tx_bit(sio_tx_bit), .sio_rx_bit_ff(sio_rx_bit_ff),
        .serial_2wire_ff(serial_2wire_ff), .par_mode(par_mode),
        .code_protect(code_protect), .par_rd(par_rd), .par_wr(par_wr),
        .par_addr(par_addr), .par_wdata(par_wdata),
        .flash_rdata(flash_rdata), .par_rdata_ff(par_rdata_ff),
        .flash_rd_ff(flash_rd_ff), .flash_wr_ff(flash_wr_ff),
        .flash_addr_ff(flash_addr_ff), .flash_wdata_ff(flash_wdata_ff),
        .par_refused_ff(par_refused_ff));
    fesc_prog_model prog (.strap_low(strap_low), .prog_en(prog_en),
        .prog_bit(prog_bit), .dev_out(mode_pin_out_ff),
        .dev_oe_n(mode_pin_oe_n_ff), .pin(mode_pin_in));

    always #25 ref_clk = ~ref_clk;

    // ****************************************************************
    // Helpers
    // ****************************************************************
    task automatic chk(input logic [PADDR_W-1:0] got, exp, input string m);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(negedge ref_clk);
    endtask
    // Bounded wait for the suspend flag (sel 0) or erase done (sel 1)
    task automatic wait_hi(input bit sel, output int k);
        k = 0;
        while ((sel ? erase_done_ff : suspended_status_flag_ff) !== 1'b1
               && k < 3000) begin
            cyc(1);
            k++;
        end
    endtask
    task automatic do_reset(input logic strap);
        strap_low = strap;
        resetn = 0;
        cyc(5);
        resetn = 1;
        cyc(2);
        strap_low = 0;
    endtask
    task automatic start_erase(input logic [BLK_W-1:0] b);
        erase_block = b;
        erase_start = 1;
        cyc(1);
        erase_start = 0;
        cyc(10);
    endtask
    // Software write of the suspend request, one cycle pulse. The handler
    // model only writes this bit and never issues a trap or break
    // instruction, since those would fetch vectors from the busy flash.
    task automatic sw_req(input logic v);
        req_value = v;
        req_write = 1;
        cyc(1);
        req_write = 0;
    endtask
    task automatic wrap_up;
        if (errors == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        #(50 * 30000);
        errors++;
        wrap_up();
    end

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        // Rows: protect, rd, wr, id equal | flash rd, flash wr, refused
        rows = '{7'b0101_100, 7'b0010_010, 7'b1101_001, 7'b1010_001};
        do_reset(0);
        chk(erase_busy_ff, 0, "busy rst");
        chk(suspended_status_flag_ff, 0, "flag rst");
        chk(mode_pin_oe_n_ff, 1, "oe rst");
        chk(serial_2wire_ff, 0, "strap high");
        foreach (rows[i]) begin
            code_protect = rows[i][6];
            par_rd = rows[i][5];
            par_wr = rows[i][4];
            id_rx = rows[i][3] ? id_stored : id_stored ^ 56'h1;
            par_addr = 16'h0100 + 16'(i);
            par_wdata = 8'ha0 + 8'(i);
            id_valid = 1;
            cyc(1);
            {par_rd, par_wr, id_valid} = 3'b000;
            chk(id_checked_ff, 1, "id checked");
            chk(id_match_ff, rows[i][3], "id match");
            chk(flash_rd_ff, rows[i][2], "flash rd");
            chk(flash_wr_ff, rows[i][1], "flash wr");
            chk(par_refused_ff, rows[i][0], "refused");
            if (rows[i][0]) chk(par_rdata_ff, 0, "rdata");
            if (rows[i][1]) chk(flash_wdata_ff, par_wdata, "wdata");
            if (rows[i][2]) chk(par_rdata_ff, flash_rdata, "rdata ok");
            chk(flash_addr_ff, par_addr, "addr");
        end
        code_protect = 0;
        // Outside parallel mode the port must stay quiet
        par_mode = 0;
        par_wr = 1;
        cyc(1);
        par_wr = 0;
        chk(flash_wr_ff, 0, "no par mode");
        chk(par_refused_ff, 0, "no par ref");
        par_mode = 1;
        // Single-wire serial: device drives, then listens
        sio_tx_en = 1;
        sio_tx_bit = 0;
        cyc(2);
        chk(mode_pin_oe_n_ff, 0, "drive");
        chk(mode_pin_in, 0, "pin lvl");
        sio_tx_en = 0;
        prog_en = 1;
        prog_bit = 0;
        cyc(3);
        chk(sio_rx_bit_ff, 0, "rx 0");
        prog_bit = 1;
        cyc(3);
        chk(sio_rx_bit_ff, 1, "rx 1");
        prog_en = 0;
        // Interrupt-driven suspend, access, resume, completion
        start_erase(3'h3);
        irq_ack = 1;
        cyc(1);
        irq_ack = 0;
        chk(erase_suspend_request_ff, 1, "auto req");
        wait_hi(0, n);
        chk(n >= SUSPEND_LATENCY_CYC && n <= SUSPEND_LATENCY_CYC + 3, 1,
            "latency");
        acc_req = 1;
        acc_block = 3'h3;
        cyc(1);
        chk(acc_grant_ff, 0, "same blk");
        acc_block = 3'h5;
        cyc(1);
        chk(acc_grant_ff, 1, "other blk");
        acc_req = 0;
        sw_req(0);
        cyc(2);
        chk(suspended_status_flag_ff, 0, "resume");
        chk(erase_busy_ff, 1, "busy");
        wait_hi(1, n);
        chk(n < ERASE_TIME_CYC - SUSPEND_LATENCY_CYC, 1, "cont");
        // Auto suspend off: erase runs on, handler writes the request
        irq_auto_suspend_enable = 0;
        start_erase(3'h1);
        irq_ack = 1;
        cyc(1);
        irq_ack = 0;
        chk(erase_suspend_request_ff, 0, "no auto");
        cyc(500);
        chk(suspended_status_flag_ff, 0, "runs on");
        sw_req(1);
        wait_hi(0, n);
        chk(n >= SUSPEND_LATENCY_CYC - 1 && n <= SUSPEND_LATENCY_CYC + 2,
            1, "sw latency");
        sw_req(0);
        wait_hi(1, n);
        chk(erase_done_ff, 1, "done");
        // Suspend disabled: requests never halt the erase
        erase_suspend_enable = 0;
        irq_auto_suspend_enable = 1;
        start_erase(3'h6);
        irq_ack = 1;
        sw_req(1);
        irq_ack = 0;
        cyc(450);
        chk(suspended_status_flag_ff, 0, "no susp");
        chk(erase_busy_ff, 1, "busy on");
        sw_req(0);
        wait_hi(1, n);
        chk(erase_done_ff, 1, "done2");
        // Strap low through reset picks two-wire: pin never driven
        do_reset(1);
        chk(serial_2wire_ff, 1, "strap low");
        sio_tx_en = 1;
        cyc(2);
        chk(mode_pin_oe_n_ff, 1, "no drive");
        wrap_up();
    end
endmodule
